// ### inc/gpio_ports_regs.svh
// Register map, field positions and reset values for the three GPIO ports
`ifndef GPIO_PORTS_REGS_SVH
`define GPIO_PORTS_REGS_SVH

`define ADDR_W 8
`define ANALOG_PORT_DATA_ADDR 8'h01
`define CAN_PORT_DATA_ADDR 8'h02
`define SPI_TIMER_PORT_DATA_ADDR 8'h03
`define ANALOG_PORT_DIRECTION_ADDR 8'h05
`define CAN_PORT_DIRECTION_ADDR 8'h06
`define SPI_TIMER_PORT_DIRECTION_ADDR 8'h07
`define CAN_PORT_PULLUP_ENABLE_ADDR 8'h0D
`define SPI_TIMER_PORT_PULLUP_ENABLE_ADDR 8'h0E
`define PERIPH_CONTROL_ADDR 8'h10
`define ADC_CHANNEL_ADDR 8'h11

`define DIR_RESET 8'h00
`define PULLUP_RESET 8'h00
`define CTRL_RESET 8'h00
`define ADC_CHANNEL_RESET 8'h1F
`define CAN_PORT_MASK 8'h7F
`define READ_ZERO 8'h00

// Fields of the peripheral control register
`define CTRL_SPI_ENABLE 0
`define CTRL_SPI_MASTER 1
`define CTRL_CAN_ENABLE 2
`define CTRL_TIMER1_CHANNEL0_PIN_ACTIVE 4
`define CTRL_TIMER1_CHANNEL1_PIN_ACTIVE 5
`define CTRL_TIMER2_CHANNEL0_PIN_ACTIVE 6
`define CTRL_TIMER2_CHANNEL1_PIN_ACTIVE 7

// Pin positions on the ports
`define PIN_SPI_SELECT 0
`define PIN_SPI_MISO 1
`define PIN_SPI_MOSI 2
`define PIN_SPI_CLOCK 3
`define PIN_CAN_TX 0
`define PIN_CAN_RX 1
`define ADC_CHANNEL_W 5
`define ADC_CHANNEL_COUNT 8

`endif

// ### inc/gpio_ports_pkg.sv
// Shared types for the GPIO port block
package gpio_ports_pkg;
    typedef logic [7:0] port_byte_t;
    typedef logic [4:0] adc_channel_t;
endpackage : gpio_ports_pkg

// ### hdl/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync (
    input wire logic mclk,
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);
    logic [7:0] meta_q;

    // No reset: pin levels carry no control state
    always_ff @(posedge mclk) begin
        meta_q <= async_in;
        sync_out <= meta_q;
    end
endmodule : pin_sync

// ### hdl/port_pin_mux.sv
// Per-pin ownership and output-enable logic for one port
`timescale 1ns/1ps
`include "gpio_ports_regs.svh"
module port_pin_mux (
    input wire logic [7:0] latch,
    input wire logic [7:0] direction,
    input wire logic [7:0] pullup_enable,
    input wire logic [7:0] periph_owns,
    input wire logic [7:0] periph_out,
    input wire logic [7:0] periph_drive,
    input wire logic [7:0] analog_force,
    input wire logic [7:0] pin_sampled,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pullup_on,
    output logic [7:0] read_value
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            always_comb begin
                if (analog_force[i]) begin
                    pin_out[i] = 1'b0;
                    pin_oe_n[i] = 1'b1;
                    pullup_on[i] = 1'b0;
                end else if (periph_owns[i]) begin
                    pin_out[i] = periph_out[i];
                    pin_oe_n[i] = ~periph_drive[i];
                    pullup_on[i] = pullup_enable[i] & ~periph_drive[i];
                end else begin
                    pin_out[i] = latch[i];
                    pin_oe_n[i] = ~direction[i];
                    pullup_on[i] = pullup_enable[i] & ~direction[i];
                end
                // Direction picks latch or pin even when a peripheral owns it
                read_value[i] = direction[i] ? latch[i] : pin_sampled[i];
            end
        end
    endgenerate
endmodule : port_pin_mux

// ### hdl/gpio_ports.sv
// GPIO logic for the analog-shared, CAN-shared and SPI/timer ports with register port
`timescale 1ns/1ps
`include "gpio_ports_regs.svh"

// Notes on behaviour
// - Analog port has an 8-bit data latch that reset leaves alone.
// - Analog direction bit 1 drives the pin; reset clears all to input.
// - Analog port read gives latch where direction is 1, else pin level.
// - Data latch writes always land; input pins read back unchanged.
// - ADC-selected analog pin is forced analog input, overriding direction and data.
// - CAN port is 7 bits; latch kept over reset, direction resets to input.
// - CAN port read gives latch where direction is 1, else pin level.
// - CAN pullup acts only on inputs; output direction disables it. With CAN enabled, bit 0 (transmit, always driven) has none and bit 1 ignores direction.
// - CAN enable turns CAN port bits 1 and 0 into CAN receive and transmit.
// - Timer edge/level select gives timer channel pins to the timer.
// - SPI disabled frees serial clock, master-out and master-in pins as GPIO.
// - On SPI pins direction only chooses latch or pin on reads.
// - Slave-select pin is GPIO when SPI is off or in master mode.
// - With SPI enabled, analog direction bit 0 has no effect on slave-select.
// - SPI/timer port has an 8-bit data latch that reset leaves alone.
// - SPI/timer port read gives latch where direction is 1, else pin level.
// - SPI/timer direction register resets to all inputs, 1 means output.
// - SPI/timer pullup acts only on inputs; output direction disables it. On pins the SPI or timer owns, their drive enable decides instead.
module gpio_ports (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [7:0] analog_pin_in,
    output logic [7:0] analog_pin_out,
    output logic [7:0] analog_pin_oe_n,
    output logic [7:0] analog_channel_pins,
    input wire logic [7:0] can_pin_in,
    output logic [7:0] can_pin_out,
    output logic [7:0] can_pin_oe_n,
    output logic [7:0] can_pullup_on,
    input wire logic can_tx,
    output logic can_rx,
    input wire logic [7:0] spi_timer_pin_in,
    output logic [7:0] spi_timer_pin_out,
    output logic [7:0] spi_timer_pin_oe_n,
    output logic [7:0] spi_timer_pullup_on,
    input wire logic spi_miso_out,
    input wire logic spi_miso_oe,
    input wire logic spi_mosi_out,
    input wire logic spi_mosi_oe,
    input wire logic spi_clock_out,
    input wire logic spi_clock_oe,
    output logic spi_miso_in,
    output logic spi_mosi_in,
    output logic spi_clock_in,
    output logic spi_select_in,
    input wire logic [3:0] timer_out,
    input wire logic [3:0] timer_oe,
    output logic [3:0] timer_in
);
    logic [7:0] analog_port_data_q;
    logic [7:0] analog_port_direction_q;
    logic [7:0] can_port_data_q;
    logic [7:0] can_port_direction_q;
    logic [7:0] can_port_pullup_enable_q;
    logic [7:0] spi_timer_port_data_q;
    logic [7:0] spi_timer_port_direction_q;
    logic [7:0] spi_timer_port_pullup_enable_q;
    logic [7:0] periph_control_q;
    gpio_ports_pkg::adc_channel_t adc_channel_q;
    logic [7:0] rdata_d;

    logic [7:0] analog_sync;
    logic [7:0] can_sync;
    logic [7:0] spi_timer_sync;

    logic spi_enable_bit;
    logic spi_master_mode_bit;
    logic can_enable_bit;
    logic [7:0] analog_force;
    logic [7:0] can_owns;
    logic [7:0] can_periph_out;
    logic [7:0] can_periph_drive;
    logic [7:0] st_owns;
    logic [7:0] st_periph_out;
    logic [7:0] st_periph_drive;
    logic [7:0] analog_read;
    logic [7:0] can_read;
    logic [7:0] st_read;
    logic [7:0] analog_out_c;
    logic [7:0] analog_oe_n_c;
    logic [7:0] can_out_c;
    logic [7:0] can_oe_n_c;
    logic [7:0] can_pu_c;
    logic [7:0] st_out_c;
    logic [7:0] st_oe_n_c;
    logic [7:0] st_pu_c;

    // Register write decode shared by every register process
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target, input logic strobe);
        hit = strobe && (a == target);
    endfunction : hit

    assign spi_enable_bit = periph_control_q[`CTRL_SPI_ENABLE];
    assign spi_master_mode_bit = periph_control_q[`CTRL_SPI_MASTER];
    assign can_enable_bit = periph_control_q[`CTRL_CAN_ENABLE];

    // Data latches have no reset
    always_ff @(posedge mclk) begin
        if (hit(addr, `ANALOG_PORT_DATA_ADDR, wr)) begin
            analog_port_data_q <= wdata;
        end
        if (hit(addr, `CAN_PORT_DATA_ADDR, wr)) begin
            can_port_data_q <= wdata & `CAN_PORT_MASK;
        end
        if (hit(addr, `SPI_TIMER_PORT_DATA_ADDR, wr)) begin
            spi_timer_port_data_q <= wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            analog_port_direction_q <= `DIR_RESET;
            can_port_direction_q <= `DIR_RESET;
            spi_timer_port_direction_q <= `DIR_RESET;
        end else begin
            if (hit(addr, `ANALOG_PORT_DIRECTION_ADDR, wr)) begin
                analog_port_direction_q <= wdata;
            end
            if (hit(addr, `CAN_PORT_DIRECTION_ADDR, wr)) begin
                can_port_direction_q <= wdata & `CAN_PORT_MASK;
            end
            if (hit(addr, `SPI_TIMER_PORT_DIRECTION_ADDR, wr)) begin
                spi_timer_port_direction_q <= wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            can_port_pullup_enable_q <= `PULLUP_RESET;
            spi_timer_port_pullup_enable_q <= `PULLUP_RESET;
        end else begin
            if (hit(addr, `CAN_PORT_PULLUP_ENABLE_ADDR, wr)) begin
                can_port_pullup_enable_q <= wdata & `CAN_PORT_MASK;
            end
            if (hit(addr, `SPI_TIMER_PORT_PULLUP_ENABLE_ADDR, wr)) begin
                spi_timer_port_pullup_enable_q <= wdata;
            end
        end
    end

    // Stand-in for the peripherals' own enable bits, which live outside this block
    always_ff @(posedge mclk) begin
        if (rst) begin
            periph_control_q <= `CTRL_RESET;
            adc_channel_q <= gpio_ports_pkg::adc_channel_t'(`ADC_CHANNEL_RESET);
        end else begin
            if (hit(addr, `PERIPH_CONTROL_ADDR, wr)) begin
                periph_control_q <= wdata;
            end
            if (hit(addr, `ADC_CHANNEL_ADDR, wr)) begin
                adc_channel_q <= wdata[`ADC_CHANNEL_W-1:0];
            end
        end
    end

    // Pin levels arrive unsynchronised from the board; two flops before any use
    pin_sync u_analog_sync (
        .mclk(mclk),
        .async_in(analog_pin_in),
        .sync_out(analog_sync)
    );
    pin_sync u_can_sync (
        .mclk(mclk),
        .async_in(can_pin_in),
        .sync_out(can_sync)
    );
    pin_sync u_st_sync (
        .mclk(mclk),
        .async_in(spi_timer_pin_in),
        .sync_out(spi_timer_sync)
    );

    // Channel codes beyond the pin count select no pin
    always_comb begin
        analog_force = `READ_ZERO;
        if (adc_channel_q < gpio_ports_pkg::adc_channel_t'(`ADC_CHANNEL_COUNT)) begin
            analog_force[adc_channel_q[2:0]] = 1'b1;
        end
    end

    always_comb begin
        can_owns = `READ_ZERO;
        can_periph_out = `READ_ZERO;
        can_periph_drive = `READ_ZERO;
        can_owns[`PIN_CAN_TX] = can_enable_bit;
        can_owns[`PIN_CAN_RX] = can_enable_bit;
        can_periph_out[`PIN_CAN_TX] = can_tx;
        can_periph_drive[`PIN_CAN_TX] = 1'b1;
    end

    always_comb begin
        st_owns = `READ_ZERO;
        st_periph_out = `READ_ZERO;
        st_periph_drive = `READ_ZERO;
        st_owns[`PIN_SPI_CLOCK] = spi_enable_bit;
        st_owns[`PIN_SPI_MOSI] = spi_enable_bit;
        st_owns[`PIN_SPI_MISO] = spi_enable_bit;
        st_owns[`PIN_SPI_SELECT] = spi_enable_bit & ~spi_master_mode_bit;
        st_periph_out[`PIN_SPI_CLOCK] = spi_clock_out;
        st_periph_drive[`PIN_SPI_CLOCK] = spi_clock_oe;
        st_periph_out[`PIN_SPI_MOSI] = spi_mosi_out;
        st_periph_drive[`PIN_SPI_MOSI] = spi_mosi_oe;
        st_periph_out[`PIN_SPI_MISO] = spi_miso_out;
        st_periph_drive[`PIN_SPI_MISO] = spi_miso_oe;
        st_owns[`CTRL_TIMER1_CHANNEL0_PIN_ACTIVE] = periph_control_q[`CTRL_TIMER1_CHANNEL0_PIN_ACTIVE];
        st_owns[`CTRL_TIMER1_CHANNEL1_PIN_ACTIVE] = periph_control_q[`CTRL_TIMER1_CHANNEL1_PIN_ACTIVE];
        st_owns[`CTRL_TIMER2_CHANNEL0_PIN_ACTIVE] = periph_control_q[`CTRL_TIMER2_CHANNEL0_PIN_ACTIVE];
        st_owns[`CTRL_TIMER2_CHANNEL1_PIN_ACTIVE] = periph_control_q[`CTRL_TIMER2_CHANNEL1_PIN_ACTIVE];
        st_periph_out[7:4] = timer_out;
        st_periph_drive[7:4] = timer_oe;
    end

    port_pin_mux u_analog_mux (
        .latch(analog_port_data_q),
        .direction(analog_port_direction_q),
        .pullup_enable(`PULLUP_RESET),
        .periph_owns(`READ_ZERO),
        .periph_out(`READ_ZERO),
        .periph_drive(`READ_ZERO),
        .analog_force(analog_force),
        .pin_sampled(analog_sync),
        .pin_out(analog_out_c),
        .pin_oe_n(analog_oe_n_c),
        .pullup_on(),
        .read_value(analog_read)
    );
    port_pin_mux u_can_mux (
        .latch(can_port_data_q),
        .direction(can_port_direction_q),
        .pullup_enable(can_port_pullup_enable_q),
        .periph_owns(can_owns),
        .periph_out(can_periph_out),
        .periph_drive(can_periph_drive),
        .analog_force(`READ_ZERO),
        .pin_sampled(can_sync),
        .pin_out(can_out_c),
        .pin_oe_n(can_oe_n_c),
        .pullup_on(can_pu_c),
        .read_value(can_read)
    );
    port_pin_mux u_st_mux (
        .latch(spi_timer_port_data_q),
        .direction(spi_timer_port_direction_q),
        .pullup_enable(spi_timer_port_pullup_enable_q),
        .periph_owns(st_owns),
        .periph_out(st_periph_out),
        .periph_drive(st_periph_drive),
        .analog_force(`READ_ZERO),
        .pin_sampled(spi_timer_sync),
        .pin_out(st_out_c),
        .pin_oe_n(st_oe_n_c),
        .pullup_on(st_pu_c),
        .read_value(st_read)
    );

    // Pin drivers registered so every output comes from a flop
    always_ff @(posedge mclk) begin
        if (rst) begin
            analog_pin_out <= `READ_ZERO;
            analog_pin_oe_n <= ~`READ_ZERO;
            analog_channel_pins <= `READ_ZERO;
            can_pin_out <= `READ_ZERO;
            can_pin_oe_n <= ~`READ_ZERO;
            can_pullup_on <= `READ_ZERO;
            spi_timer_pin_out <= `READ_ZERO;
            spi_timer_pin_oe_n <= ~`READ_ZERO;
            spi_timer_pullup_on <= `READ_ZERO;
        end else begin
            analog_pin_out <= analog_out_c;
            analog_pin_oe_n <= analog_oe_n_c;
            analog_channel_pins <= analog_force;
            can_pin_out <= can_out_c & `CAN_PORT_MASK;
            can_pin_oe_n <= can_oe_n_c | ~`CAN_PORT_MASK;
            can_pullup_on <= can_pu_c & `CAN_PORT_MASK;
            spi_timer_pin_out <= st_out_c;
            spi_timer_pin_oe_n <= st_oe_n_c;
            spi_timer_pullup_on <= st_pu_c;
        end
    end

    // Pin levels towards the peripherals, quiet while they do not own the pin
    always_ff @(posedge mclk) begin
        if (rst) begin
            can_rx <= 1'b1;
            spi_miso_in <= 1'b0;
            spi_mosi_in <= 1'b0;
            spi_clock_in <= 1'b0;
            spi_select_in <= 1'b1;
            timer_in <= 4'h0;
        end else begin
            can_rx <= can_enable_bit ? can_sync[`PIN_CAN_RX] : 1'b1;
            spi_miso_in <= spi_enable_bit & spi_timer_sync[`PIN_SPI_MISO];
            spi_mosi_in <= spi_enable_bit & spi_timer_sync[`PIN_SPI_MOSI];
            spi_clock_in <= spi_enable_bit & spi_timer_sync[`PIN_SPI_CLOCK];
            spi_select_in <= st_owns[`PIN_SPI_SELECT] ? spi_timer_sync[`PIN_SPI_SELECT] : 1'b1;
            timer_in <= spi_timer_sync[7:4] & st_owns[7:4];
        end
    end

    // Register read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = `READ_ZERO;
        unique case (addr)
            `ANALOG_PORT_DATA_ADDR: rdata_d = analog_read;
            `CAN_PORT_DATA_ADDR: rdata_d = can_read & `CAN_PORT_MASK;
            `SPI_TIMER_PORT_DATA_ADDR: rdata_d = st_read;
            `ANALOG_PORT_DIRECTION_ADDR: rdata_d = analog_port_direction_q;
            `CAN_PORT_DIRECTION_ADDR: rdata_d = can_port_direction_q;
            `SPI_TIMER_PORT_DIRECTION_ADDR: rdata_d = spi_timer_port_direction_q;
            `CAN_PORT_PULLUP_ENABLE_ADDR: rdata_d = can_port_pullup_enable_q;
            `SPI_TIMER_PORT_PULLUP_ENABLE_ADDR: rdata_d = spi_timer_port_pullup_enable_q;
            `PERIPH_CONTROL_ADDR: rdata_d = periph_control_q;
            `ADC_CHANNEL_ADDR: rdata_d = {3'h0, adc_channel_q};
            default: rdata_d = `READ_ZERO;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= `READ_ZERO;
        end else if (rd) begin
            rdata <= rdata_d;
        end else begin
            rdata <= `READ_ZERO;
        end
    end
endmodule : gpio_ports

// ### tb/gpio_ports_monitor.sv
// Concurrent checks on the outputs of the GPIO port block
`timescale 1ns/1ps
`include "gpio_ports_regs.svh"
module gpio_ports_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [7:0] analog_pin_out,
    input wire logic [7:0] analog_pin_oe_n,
    input wire logic [7:0] analog_channel_pins,
    input wire logic [7:0] can_pin_oe_n,
    input wire logic [7:0] can_pullup_on,
    input wire logic [7:0] spi_timer_pin_oe_n,
    input wire logic [7:0] spi_timer_pullup_on,
    input wire logic spi_select_in
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_RESET_INPUTS: assert property ($fell(rst) |-> analog_pin_oe_n == 8'hFF && can_pin_oe_n == 8'hFF
        && spi_timer_pin_oe_n == 8'hFF && spi_select_in) else $error("pins not released after reset");
    AST_DIR_WRITE: assert property (wr && addr == `ANALOG_PORT_DIRECTION_ADDR |-> ##2
        (analog_pin_oe_n | analog_channel_pins) == (~$past(wdata, 2) | analog_channel_pins))
        else $error("analog output enables do not follow direction write");
    AST_DATA_DRIVE: assert property (wr && addr == `ANALOG_PORT_DATA_ADDR |-> ##2
        ((analog_pin_out ^ $past(wdata, 2)) & ~analog_pin_oe_n) == 8'h00)
        else $error("driven analog pins do not show written data");
    AST_FORCED_IDLE: assert property ((analog_channel_pins & ~analog_pin_oe_n) == 8'h00)
        else $error("converter input pin is driven");
    AST_ONE_CHANNEL: assert property ($onehot0(analog_channel_pins))
        else $error("more than one converter input pin");
    AST_CAN_BIT7: assert property (can_pin_oe_n[7] && !can_pullup_on[7])
        else $error("unused CAN port bit active");
    AST_CAN_PULLUP: assert property ((can_pullup_on & ~can_pin_oe_n) == 8'h00)
        else $error("CAN port pullup on a driven pin");
    AST_SPI_PULLUP: assert property ((spi_timer_pullup_on & ~spi_timer_pin_oe_n) == 8'h00)
        else $error("SPI timer port pullup on a driven pin");
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside the read answer cycle");
endmodule : gpio_ports_monitor

// ### tb/board_model.sv
// Board wiring on one port: device drive, external driver, pullup or floating wire
`timescale 1ns/1ps
module board_model (
    input wire logic mclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_level
);
    // A floating pin toggles so that no stale level can pass for a real one
    logic [7:0] float_q = 8'h55;
    always_ff @(posedge mclk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_level[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_level[i] = ext_val[i];
            end else if (pullup_on[i]) begin
                pin_level[i] = 1'b1;
            end else begin
                pin_level[i] = float_q[i];
            end
        end
    end
endmodule : board_model

// ### tb/testbench.sv
// Register-level tests of the GPIO port block with board models on all pins
`timescale 1ns/1ps
`include "gpio_ports_regs.svh"
module testbench;
    logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, can_tx = 1'b0, can_rx;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [7:0] analog_pin_in, analog_pin_out, analog_pin_oe_n, analog_channel_pins;
    logic [7:0] can_pin_in, can_pin_out, can_pin_oe_n, can_pullup_on;
    logic [7:0] spi_timer_pin_in, spi_timer_pin_out, spi_timer_pin_oe_n, spi_timer_pullup_on;
    logic spi_miso_out = 1'b0, spi_miso_oe = 1'b0, spi_mosi_out = 1'b0, spi_mosi_oe = 1'b0;
    logic spi_clock_out = 1'b1, spi_clock_oe = 1'b1;
    logic spi_miso_in, spi_mosi_in, spi_clock_in, spi_select_in;
    logic [3:0] timer_out = 4'h0, timer_oe = 4'h0, timer_in;
    logic [7:0] an_ext = 8'h00, an_en = 8'h00, cn_ext = 8'h00, cn_en = 8'h00, st_ext = 8'h00, st_en = 8'h00;
    int n_mismatch = 0, total_checks = 0;
    always #20 mclk = ~mclk;

    gpio_ports gpio_ports_i (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .analog_pin_in, .analog_pin_out,
        .analog_pin_oe_n, .analog_channel_pins, .can_pin_in, .can_pin_out, .can_pin_oe_n, .can_pullup_on,
        .can_tx, .can_rx, .spi_timer_pin_in, .spi_timer_pin_out, .spi_timer_pin_oe_n, .spi_timer_pullup_on,
        .spi_miso_out, .spi_miso_oe, .spi_mosi_out, .spi_mosi_oe, .spi_clock_out, .spi_clock_oe,
        .spi_miso_in, .spi_mosi_in, .spi_clock_in, .spi_select_in, .timer_out, .timer_oe, .timer_in);
    board_model board_an (.mclk, .pin_out(analog_pin_out), .pin_oe_n(analog_pin_oe_n), .pullup_on(8'h00),
        .ext_val(an_ext), .ext_en(an_en), .pin_level(analog_pin_in));
    board_model board_cn (.mclk, .pin_out(can_pin_out), .pin_oe_n(can_pin_oe_n), .pullup_on(can_pullup_on),
        .ext_val(cn_ext), .ext_en(cn_en), .pin_level(can_pin_in));
    board_model board_st (.mclk, .pin_out(spi_timer_pin_out), .pin_oe_n(spi_timer_pin_oe_n),
        .pullup_on(spi_timer_pullup_on), .ext_val(st_ext), .ext_en(st_en), .pin_level(spi_timer_pin_in));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string name);
        total_checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            n_mismatch++;
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 check(rdata, exp, name);
    endtask : rd_chk
    // Pin outputs settle two edges after the write; synced pin inputs need two more
    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask : settle
    task automatic do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
    endtask : do_reset
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end

    initial begin
        static logic [7:0] ra[7] = '{8'h05, 8'h06, 8'h07, 8'h0D, 8'h0E, 8'h10, 8'h11};
        static logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1F};
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i], "reset value");
        rd_chk(8'h20, 8'h00, "unmapped read");
        wr_reg(8'h20, 8'hFF);
        rd_chk(8'h20, 8'h00, "unmapped after write");
        $display("test reset and map done");
        an_en <= 8'hFF;
        an_ext <= 8'h3C;
        wr_reg(`ANALOG_PORT_DATA_ADDR, 8'hA5);
        wr_reg(`ANALOG_PORT_DIRECTION_ADDR, 8'h0F);
        settle();
        check(analog_pin_oe_n, 8'hF0, "analog enables");
        check(analog_pin_out & 8'h0F, 8'h05, "analog drive");
        rd_chk(`ANALOG_PORT_DATA_ADDR, 8'h35, "analog read mix");
        wr_reg(`ANALOG_PORT_DATA_ADDR, 8'h5A);
        settle();
        rd_chk(`ANALOG_PORT_DATA_ADDR, 8'h3A, "analog write to inputs");
        wr_reg(`ADC_CHANNEL_ADDR, 8'h02);
        settle();
        check(analog_channel_pins, 8'h04, "converter pin");
        check(analog_pin_oe_n, 8'hF4, "converter pin released");
        wr_reg(`ADC_CHANNEL_ADDR, 8'h1F);
        $display("test analog port done");
        wr_reg(`CAN_PORT_DATA_ADDR, 8'h55);
        wr_reg(`CAN_PORT_DIRECTION_ADDR, 8'hF0);
        wr_reg(`CAN_PORT_PULLUP_ENABLE_ADDR, 8'hFF);
        settle();
        check(can_pullup_on, 8'h0F, "can pullups");
        check(can_pin_oe_n, 8'h8F, "can enables");
        rd_chk(`CAN_PORT_DIRECTION_ADDR, 8'h70, "can direction bit7");
        rd_chk(`CAN_PORT_PULLUP_ENABLE_ADDR, 8'h7F, "can pullup bit7");
        rd_chk(`CAN_PORT_DATA_ADDR, 8'h5F, "can read mix");
        wr_reg(`CAN_PORT_PULLUP_ENABLE_ADDR, 8'h00);
        wr_reg(`CAN_PORT_DIRECTION_ADDR, 8'h00);
        cn_en <= 8'h02;
        wr_reg(`PERIPH_CONTROL_ADDR, 8'h04);
        settle();
        check({6'h00, can_rx, can_pin_oe_n[0]}, 8'h00, "can receive low, transmit driven");
        can_tx <= 1'b1;
        cn_ext <= 8'h02;
        settle();
        check({6'h00, can_rx, can_pin_out[0]}, 8'h03, "can receive and transmit high");
        $display("test can port done");
        st_en <= 8'hF1;
        st_ext <= 8'h50;
        wr_reg(`SPI_TIMER_PORT_DATA_ADDR, 8'h00);
        wr_reg(`SPI_TIMER_PORT_DIRECTION_ADDR, 8'hF6);
        wr_reg(`PERIPH_CONTROL_ADDR, 8'h01);
        settle();
        check({7'h00, spi_select_in}, 8'h00, "slave select input");
        check({6'h00, spi_timer_pin_oe_n[3], spi_timer_pin_out[3]}, 8'h01, "spi clock drive");
        rd_chk(`SPI_TIMER_PORT_DATA_ADDR, 8'h08, "spi port read mix");
        wr_reg(`SPI_TIMER_PORT_DIRECTION_ADDR, 8'hFF);
        wr_reg(`ANALOG_PORT_DIRECTION_ADDR, 8'h01);
        settle();
        rd_chk(`SPI_TIMER_PORT_DATA_ADDR, 8'h00, "spi port read latch");
        check({6'h00, spi_timer_pin_oe_n[0], spi_select_in}, 8'h02, "select pin kept input");
        wr_reg(`PERIPH_CONTROL_ADDR, 8'h03);
        settle();
        check({6'h00, spi_timer_pin_oe_n[0], spi_select_in}, 8'h01, "select pin general in master");
        wr_reg(`SPI_TIMER_PORT_DIRECTION_ADDR, 8'h00);
        wr_reg(`PERIPH_CONTROL_ADDR, 8'h00);
        settle();
        check({4'h0, spi_miso_in, spi_mosi_in, spi_clock_in, spi_timer_pin_oe_n[3]}, 8'h01, "spi off");
        timer_oe <= 4'h3;
        timer_out <= 4'h1;
        st_en <= 8'hC1;
        wr_reg(`PERIPH_CONTROL_ADDR, 8'hF0);
        settle();
        check({spi_timer_pin_oe_n[7:4], 2'b00, spi_timer_pin_out[5:4]}, 8'hC1, "timer drive");
        check({6'h00, timer_in[3:2]}, 8'h01, "timer capture input");
        wr_reg(`PERIPH_CONTROL_ADDR, 8'h00);
        settle();
        check({spi_timer_pin_oe_n[7:4], timer_in}, 8'hF0, "timer released");
        wr_reg(`SPI_TIMER_PORT_PULLUP_ENABLE_ADDR, 8'hFF);
        wr_reg(`SPI_TIMER_PORT_DIRECTION_ADDR, 8'h0F);
        settle();
        check(spi_timer_pullup_on, 8'hF0, "spi timer pullups");
        rd_chk(`SPI_TIMER_PORT_PULLUP_ENABLE_ADDR, 8'hFF, "spi timer pullup reg");
        $display("test spi timer port done");
        do_reset();
        #1 check(analog_pin_oe_n, 8'hFF, "enables after reset");
        rd_chk(`ANALOG_PORT_DIRECTION_ADDR, 8'h00, "direction after reset");
        wr_reg(`ANALOG_PORT_DIRECTION_ADDR, 8'hFF);
        wr_reg(`SPI_TIMER_PORT_DIRECTION_ADDR, 8'hFF);
        wr_reg(`CAN_PORT_DIRECTION_ADDR, 8'hFF);
        settle();
        rd_chk(`ANALOG_PORT_DATA_ADDR, 8'h5A, "analog latch kept");
        rd_chk(`CAN_PORT_DATA_ADDR, 8'h55, "can latch kept");
        rd_chk(`SPI_TIMER_PORT_DATA_ADDR, 8'h00, "spi latch kept");
        $display("test reset persistence done");
        summarize();
    end
endmodule : testbench

bind gpio_ports gpio_ports_monitor gpio_ports_monitor_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .analog_pin_out(analog_pin_out), .analog_pin_oe_n(analog_pin_oe_n),
    .analog_channel_pins(analog_channel_pins), .can_pin_oe_n(can_pin_oe_n), .can_pullup_on(can_pullup_on),
    .spi_timer_pin_oe_n(spi_timer_pin_oe_n), .spi_timer_pullup_on(spi_timer_pullup_on),
    .spi_select_in(spi_select_in));
